/* include/pmb_pkg.sv */
// Purpose: shared constants and types for the program memory bus block
// Assumes: one clock, 50 MHz, active-low asynchronous reset
// Notes:   mode encoding follows the two configuration bits, erased = 2'b11
`default_nettype none
package pmb_pkg;
    localparam int          PC_WIDTH      = 16;
    localparam int          WORD_WIDTH    = 16;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] VEC_INT_PIN   = 16'h0008;
    localparam logic [15:0] VEC_TIMER     = 16'h0010;
    localparam logic [15:0] VEC_CLK_PIN   = 16'h0018;
    localparam logic [15:0] VEC_PERIPH    = 16'h0020;
    // Default size of on-chip program memory in words
    localparam logic [16:0] INT_MEM_WORDS = 17'h0_4000;
    localparam logic [15:0] UNDEF_WORD    = 16'hFFFF;
    // Bus phase lengths in clock cycles
    localparam logic [1:0]  ADDR_CYCLES   = 2'h1;
    localparam logic [1:0]  READ_CYCLES   = 2'h2;
    // Control lines on the low bits of the control port
    localparam int          CTL_ALE       = 0;
    localparam int          CTL_OE_N      = 1;
    localparam int          CTL_WR_N      = 2;
    localparam logic [2:0]  CTL_IDLE      = 3'h6;

    typedef enum logic [1:0] {
        PMB_MODE_PROTECTED = 2'h0,
        PMB_MODE_EXTENDED  = 2'h1,
        PMB_MODE_MCU       = 2'h2,
        PMB_MODE_MPU       = 2'h3
    } pmb_mode_t;

    typedef enum logic [3:0] {
        PMB_ST_IDLE = 4'b0001,
        PMB_ST_ADDR = 4'b0010,
        PMB_ST_READ = 4'b0100,
        PMB_ST_DONE = 4'b1000
    } pmb_state_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } pmb_fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } pmb_fetch_rsp_t;

    typedef struct packed {
        logic [7:0] lowOut;
        logic [7:0] lowOe_n;
        logic [7:0] highOut;
        logic [7:0] highOe_n;
        logic [2:0] ctlOut;
        logic [2:0] ctlOe_n;
    } pmb_pins_t;

    typedef struct packed {
        logic internalOk;
        logic externalOk;
        logic specialOk;
        logic busEnable;
        logic protect;
    } pmb_access_t;
endpackage
`default_nettype wire

/* hdl/pmb_mode_decode.sv */
// Purpose: decode configuration bits into the memory access rights
// Assumes: config bits are static after reset
// Notes:   pure combinational
`timescale 1ns/100ps
`default_nettype none
module pmb_mode_decode
    import pmb_pkg::*;
(
    input  wire logic [1:0] configBits,
    output pmb_access_t     access
);
    pmb_mode_t mode;

    always_comb begin
        mode = pmb_mode_t'(configBits);
        access = '0;
        unique case (mode)
            PMB_MODE_MPU: begin
                access.externalOk = 1'b1;
                access.busEnable  = 1'b1;
            end
            PMB_MODE_EXTENDED: begin
                access.internalOk = 1'b1;
                access.externalOk = 1'b1;
                access.busEnable  = 1'b1;
            end
            PMB_MODE_MCU: begin
                access.internalOk = 1'b1;
                access.specialOk  = 1'b1;
            end
            PMB_MODE_PROTECTED: begin
                access.internalOk = 1'b1;
                access.specialOk  = 1'b1;
                access.protect    = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

/* hdl/pmb_program_bus.sv */
// Purpose: program fetch routing and multiplexed external program bus
// Assumes: core issues one fetch at a time and waits for fetchRsp.valid
// Notes:   data memory never leaves the chip; its bus is separate from this one
//          requests made while a fetch is in flight are dropped, not queued
`timescale 1ns/100ps
`default_nettype none
module pmb_program_bus
    import pmb_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    input  wire logic           clkEn,
    input  wire logic [1:0]     configBits,
    input  wire pmb_fetch_req_t fetchReq,
    input  wire logic [2:0]     vectorSel,
    input  wire logic           vectorTake,
    input  wire logic           specialReq,
    input  wire logic [15:0]    intMemWord,
    input  wire logic [7:0]     adLowIn,
    input  wire logic [7:0]     adHighIn,
    output pmb_fetch_rsp_t      fetchRsp,
    output logic [15:0]         startAddr,
    output logic [15:0]         intMemAddr,
    output logic                specialGrant,
    output logic                codeProtect,
    output logic                busActive,
    output pmb_pins_t           pins
);
    typedef struct packed {
        pmb_state_t     state;
        // Cycles spent in the present bus phase
        logic [1:0]     count;
        // Fetch goes to the pads rather than the array
        logic           external;
        logic [15:0]    addr;
        pmb_fetch_rsp_t rsp;
        logic [15:0]    start;
        logic [15:0]    intAddr;
        logic           grant;
        logic           protect;
        logic           bus;
        pmb_pins_t      pins;
    } pmb_core_t;

    pmb_core_t   cur;
    pmb_core_t   next_cur;
    pmb_access_t access;
    logic        inRange;
    logic        heldInRange;
    logic        takeFetch;
    logic        goExternal;
    logic        addrPhaseEnd;
    logic        readPhaseEnd;
    logic [15:0] vecAddr;

    // Reset image in one place, so the reset branch assigns only a constant
    localparam pmb_core_t CORE_RESET = '{
        state:    PMB_ST_IDLE,
        count:    2'h0,
        external: 1'b0,
        addr:     16'h0000,
        rsp:      '0,
        start:    RESET_VECTOR,
        intAddr:  16'h0000,
        grant:    1'b0,
        protect:  1'b0,
        bus:      1'b0,
        pins:     '{
            lowOut:   8'h00,
            lowOe_n:  8'hFF,
            highOut:  8'h00,
            highOe_n: 8'hFF,
            ctlOut:   CTL_IDLE,
            ctlOe_n:  3'h7
        }
    };

    pmb_mode_decode u_decode (
        .configBits (configBits),
        .access     (access)
    );

    always_comb begin
        inRange = {1'b0, fetchReq.addr} < INT_MEM_WORDS;
        // The request is gone by the answer cycle, so judge the held address
        heldInRange = {1'b0, cur.addr} < INT_MEM_WORDS;
        // Requests while busy are dropped rather than queued
        takeFetch = fetchReq.valid && (cur.state == PMB_ST_IDLE);
        goExternal = access.externalOk & ~(access.internalOk & inRange);
        addrPhaseEnd = (cur.count + 2'h1) >= ADDR_CYCLES;
        readPhaseEnd = (cur.count + 2'h1) >= READ_CYCLES;
        unique case (vectorSel)
            3'h1:    vecAddr = VEC_INT_PIN;
            3'h2:    vecAddr = VEC_TIMER;
            3'h3:    vecAddr = VEC_CLK_PIN;
            3'h4:    vecAddr = VEC_PERIPH;
            default: vecAddr = RESET_VECTOR;
        endcase
    end

    always_comb begin
        next_cur = cur;
        next_cur.rsp.valid = 1'b0;
        next_cur.protect = access.protect;
        next_cur.grant = specialReq & access.specialOk;
        next_cur.bus = access.busEnable;
        // Program fetches never write, so the write strobe stays idle
        next_cur.pins.ctlOut[CTL_WR_N] = 1'b1;
        if (vectorTake) begin
            next_cur.start = vecAddr;
        end
        // Data memory has its own path in the core; nothing here touches it
        unique case (cur.state)
            PMB_ST_IDLE: begin
                next_cur.pins.ctlOut = CTL_IDLE;
                next_cur.pins.lowOe_n = 8'hFF;
                next_cur.pins.highOe_n = 8'hFF;
                if (takeFetch) begin
                    next_cur.addr = fetchReq.addr;
                    next_cur.external = goExternal;
                    next_cur.intAddr = fetchReq.addr;
                    next_cur.count = '0;
                    if (access.busEnable) begin
                        // Address goes out even for internal fetches so control keeps toggling
                        next_cur.pins.lowOut = fetchReq.addr[7:0];
                        next_cur.pins.highOut = fetchReq.addr[15:8];
                        next_cur.pins.lowOe_n = 8'h00;
                        next_cur.pins.highOe_n = 8'h00;
                        next_cur.pins.ctlOut[CTL_ALE] = 1'b1;
                        next_cur.state = PMB_ST_ADDR;
                    end else begin
                        next_cur.state = PMB_ST_DONE;
                    end
                end
            end

            PMB_ST_ADDR: begin
                next_cur.count = cur.count + 2'h1;
                if (addrPhaseEnd) begin
                    // Outside latch captures on the falling strobe
                    next_cur.pins.ctlOut[CTL_ALE] = 1'b0;
                    next_cur.pins.lowOe_n = 8'hFF;
                    next_cur.pins.highOe_n = 8'hFF;
                    next_cur.pins.ctlOut[CTL_OE_N] = 1'b0;
                    next_cur.count = '0;
                    next_cur.state = PMB_ST_READ;
                end
            end

            PMB_ST_READ: begin
                next_cur.count = cur.count + 2'h1;
                if (readPhaseEnd) begin
                    next_cur.pins.ctlOut[CTL_OE_N] = 1'b1;
                    next_cur.state = PMB_ST_DONE;
                    if (cur.external) begin
                        next_cur.rsp.word = {adHighIn, adLowIn};
                    end else begin
                        next_cur.rsp.word = intMemWord;
                    end
                end
            end

            PMB_ST_DONE: begin
                next_cur.rsp.valid = 1'b1;
                next_cur.pins.ctlOut = CTL_IDLE;
                if (!cur.bus) begin
                    // Past the array the internal word is undefined; a fixed filler stands in
                    next_cur.rsp.word = heldInRange ? intMemWord : UNDEF_WORD;
                end
                next_cur.state = PMB_ST_IDLE;
            end

            // Illegal one-hot code: recover to idle
            default: begin
                next_cur.state = PMB_ST_IDLE;
            end
        endcase

        // Pads stay released in the internal modes so the ports keep other jobs
        if (!access.busEnable) begin
            next_cur.pins.lowOe_n = 8'hFF;
            next_cur.pins.highOe_n = 8'hFF;
            next_cur.pins.ctlOe_n = 3'h7;
        end else begin
            next_cur.pins.ctlOe_n = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur <= CORE_RESET;
        end else if (clkEn) begin
            cur <= next_cur;
        end
    end

    // Every output is a register field
    assign fetchRsp = cur.rsp;
    assign startAddr = cur.start;
    assign intMemAddr = cur.intAddr;
    assign specialGrant = cur.grant;
    assign codeProtect = cur.protect;
    assign busActive = cur.bus;
    assign pins = cur.pins;
endmodule
`default_nettype wire

/* verification/pmb_program_bus_props.sv */
// Purpose: port-level checks of the program bus block
// Assumes: clkEn high while a fetch is in flight, mode bits static between resets
// Notes:   bound into every instance of the block
`timescale 1ns/100ps
`default_nettype none
module pmb_program_bus_props
    import pmb_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           rst_n,
    input wire logic [1:0]     configBits,
    input wire pmb_fetch_req_t fetchReq,
    input wire logic           specialReq,
    input wire pmb_fetch_rsp_t fetchRsp,
    input wire logic           specialGrant,
    input wire logic           codeProtect,
    input wire logic           busActive,
    input wire pmb_pins_t      pins
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_protect_mode: assert property (
        1 |=> codeProtect == (configBits == PMB_MODE_PROTECTED)) else $error("protect flag");
    a_bus_mode: assert property (
        1 |=> busActive == (configBits inside {PMB_MODE_MPU, PMB_MODE_EXTENDED}))
        else $error("bus mode flag");
    a_special_grant: assert property (
        1 |=> specialGrant == ($past(specialReq) && !configBits[0])) else $error("grant");
    a_ext_timing: assert property (
        fetchReq.valid && busActive |-> ##5 fetchRsp.valid) else $error("bus answer late");
    a_int_timing: assert property (
        fetchReq.valid && !busActive |-> ##2 fetchRsp.valid) else $error("inner answer late");
    a_latch_phase: assert property (
        pins.ctlOut[CTL_ALE] |-> pins.highOe_n == 8'h00
        ##1 pins.lowOe_n == 8'hFF && !pins.ctlOut[CTL_OE_N]) else $error("latch phase");
    a_read_width: assert property (
        $fell(pins.ctlOut[CTL_OE_N]) |=> !pins.ctlOut[CTL_OE_N] ##1 pins.ctlOut[CTL_OE_N])
        else $error("read strobe width");
    a_addr_out: assert property (
        fetchReq.valid && busActive |=> {pins.highOut, pins.lowOut} == $past(fetchReq.addr))
        else $error("address on bus");
endmodule
bind pmb_program_bus pmb_program_bus_props props_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .configBits(configBits), .fetchReq(fetchReq),
    .specialReq(specialReq), .fetchRsp(fetchRsp), .specialGrant(specialGrant),
    .codeProtect(codeProtect), .busActive(busActive), .pins(pins));
`default_nettype wire

/* verification/pmb_ext_mem.sv */
// Purpose: address latch and program memory outside the AD bus
// Assumes: sampled on the core clock
// Notes:   stored word is the latched address XOR a fixed pattern
`timescale 1ns/100ps
`default_nettype none
module pmb_ext_mem
    import pmb_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire pmb_pins_t pins,
    output logic [7:0]     adLowIn,
    output logic [7:0]     adHighIn
);
    logic [15:0] latchAddr = 16'h0000;
    logic [15:0] floatPat  = 16'h0000;
    logic [15:0] farWord;
    always @(posedge clk_sys) begin
        if (pins.ctlOut[CTL_ALE]) latchAddr <= {pins.highOut, pins.lowOut};
        floatPat <= ~floatPat;
    end
    // Off the read strobe the lines float, so show a toggling pattern
    assign farWord  = !pins.ctlOut[CTL_OE_N] ? latchAddr ^ 16'hA5C3 : floatPat;
    assign adLowIn  = (pins.lowOe_n == 8'h00) ? pins.lowOut : farWord[7:0];
    assign adHighIn = (pins.highOe_n == 8'h00) ? pins.highOut : farWord[15:8];
endmodule
`default_nettype wire

/* verification/pmb_program_bus_bench.sv */
// Purpose: self-checking bench for the program bus block
// Assumes: clkEn high except in the freeze scenario, inputs move on falling edges
// Notes:   mode bits are static, so each mode gets its own reset
`timescale 1ns/100ps
`default_nettype none
module pmb_program_bus_bench
    import pmb_pkg::*;
;
    logic           clk_sys, rst_n, clkEn, vectorTake, specialReq;
    logic           specialGrant, codeProtect, busActive;
    logic [1:0]     configBits;
    logic [2:0]     vectorSel;
    logic [7:0]     adLowIn, adHighIn;
    logic [15:0]    intMemWord, startAddr, intMemAddr;
    pmb_fetch_req_t fetchReq;
    pmb_fetch_rsp_t fetchRsp;
    pmb_pins_t      pins;
    int             mismatches, cmp_count, cycles;

    pmb_program_bus dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .configBits(configBits),
        .fetchReq(fetchReq), .vectorSel(vectorSel), .vectorTake(vectorTake),
        .specialReq(specialReq), .intMemWord(intMemWord), .adLowIn(adLowIn),
        .adHighIn(adHighIn), .fetchRsp(fetchRsp), .startAddr(startAddr),
        .intMemAddr(intMemAddr), .specialGrant(specialGrant),
        .codeProtect(codeProtect), .busActive(busActive), .pins(pins));
    pmb_ext_mem far_u (.clk_sys(clk_sys), .pins(pins), .adLowIn(adLowIn), .adHighIn(adHighIn));
    // Differs from the far memory, so a wrong source shows
    assign intMemWord = intMemAddr ^ 16'h3C3C;

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] mode);
        configBits = mode;
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic fetch(input logic [15:0] addr, input logic [15:0] exp);
        fetchReq = '{valid: 1'b1, addr: addr};
        @(negedge clk_sys);
        fetchReq.valid = 1'b0;
        for (int n = 0; n < 8 && fetchRsp.valid !== 1'b1; n++) @(negedge clk_sys);
        check({15'h0000, fetchRsp.valid}, 16'h0001);
        check(fetchRsp.word, exp);
        check(intMemAddr, addr);
    endtask
    task automatic vector_case();
        do_reset(PMB_MODE_MPU);
        check(startAddr, 16'h0000);
        // Strobe held up across the table, one vector per cycle
        vectorTake = 1'b1;
        for (int i = 0; i < 6; i++) begin
            vectorSel = 3'(i);
            @(negedge clk_sys);
            check(startAddr, i < 5 ? 16'(i * 8) : 16'h0000);
        end
        vectorTake = 1'b0;
    endtask
    task automatic freeze_case();
        @(negedge clk_sys);
        vectorSel = 3'h2;
        vectorTake = 1'b1;
        clkEn = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(startAddr, 16'h0000);
        clkEn = 1'b1;
        @(negedge clk_sys);
        check(startAddr, 16'h0010);
        vectorTake = 1'b0;
    endtask
    task automatic mode_case(input logic [1:0] mode);
        logic [15:0] probe [4] = '{16'h0010, 16'h3FFF, 16'h4000, 16'hFFFF};
        logic ext, bus, inner;
        ext = mode == PMB_MODE_MPU;
        bus = ext || mode == PMB_MODE_EXTENDED;
        specialReq = 1'b1;
        do_reset(mode);
        check({15'h0000, codeProtect}, {15'h0000, mode == PMB_MODE_PROTECTED});
        check({15'h0000, busActive}, {15'h0000, bus});
        check({15'h0000, specialGrant}, {15'h0000, !bus});
        check({13'h0000, pins.ctlOe_n}, {13'h0000, (bus ? 3'h0 : 3'h7)});
        check({13'h0000, pins.ctlOut}, 16'h0006);
        foreach (probe[i]) begin
            inner = probe[i] < 16'h4000;
            fetch(probe[i], ext || bus && !inner ? probe[i] ^ 16'hA5C3
                : inner ? probe[i] ^ 16'h3C3C : 16'hFFFF);
        end
        specialReq = 1'b0;
        @(negedge clk_sys);
        check({15'h0000, specialGrant}, 16'h0000);
    endtask

    initial begin
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        fetchReq = '0;
        vectorSel = 3'h0;
        vectorTake = 1'b0;
        specialReq = 1'b0;
        clkEn = 1'b1;
        vector_case();
        freeze_case();
        for (int m = 0; m < 4; m++) mode_case(2'(m));
        stop_test();
    end
endmodule
`default_nettype wire
